// ### rtl/power_path_pkg.sv
// Function
// [RULE1] The block resets on the internal power-on reset or while the external active-low reset is low.
// [RULE2] An outside party holds the external reset low for at least one microsecond to reset the block; the code needs 41 low cycles (1025 ns).
// [RULE3] The management link has this device as I2C slave and the embedded controller as master.
// [RULE4] The device pulls its event interrupt output low when a Type-C or PD event such as attach, detach or role swap begins.
// [RULE5] On low battery charge the embedded controller asks over I2C for a lower current contract.
// [RULE6] Each port has two separate outputs, one for the source path and one for the sink path.
// [RULE7] The sink-path enable is active high: high turns the consumer path on, low turns it off.
// [RULE8] The source-path enable is active high: high turns the provider path on, low turns it off.
// [RULE9] The bus bleed control is active high and enables the external Bus_bleed_ctrl path.
// [RULE10] The bus bleed control is asserted after a high-voltage contract ends, on detach or on a role swap.
// [RULE11] Once powered, the dead-battery terminations are disabled and the active sink terminations used.
// [RULE12] After dead-battery power-up the device requests a higher VBUS as its configuration allows.
// [RULE13] Source and sink enables of one port are never high together; one drops before the other rises.
package power_path_pkg;

  localparam int          NUM_PORTS       = 2;
  localparam int          CLK_FREQ_HZ     = 40_000_000;
  localparam int          EXT_RESET_MIN_NS = 1000;
  localparam int          CLK_PERIOD_NS   = 1_000_000_000 / CLK_FREQ_HZ;
  // Least hold time of the external reset, rounded up to whole cycles.
  localparam int          EXT_RESET_CYCLES =
    (EXT_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          BLEED_TIME_NS   = 10_000;
  localparam int          BLEED_CYCLES    = BLEED_TIME_NS / CLK_PERIOD_NS;
  localparam int          SWAP_GAP_NS     = 250;
  localparam int          SWAP_GAP_CYCLES = SWAP_GAP_NS / CLK_PERIOD_NS;
  localparam int          TIMER_WIDTH     = 10;
  localparam int          RST_CNT_WIDTH   = 6;

  typedef enum logic [2:0] {
    PORT_IDLE   = 3'h0,
    PORT_SINK   = 3'h5,
    PORT_SOURCE = 3'h6,
    PORT_BLEED  = 3'h7,
    PORT_GAP    = 3'h4
  } port_state_type;

endpackage

// ### rtl/port_path_fsm.sv
`timescale 1ns/1ps
`default_nettype none
module port_path_fsm
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  // Requests
  input  wire logic attached,
  input  wire logic want_source,
  input  wire logic high_voltage,
  // Path controls
  output logic      sink_path_en,
  output logic      source_path_en,
  output logic      bus_bleed_ctrl,
  output logic      event_pulse
);
  import power_path_pkg::*;

  port_state_type                 state_r;
  port_state_type                 state_nxt;
  logic [TIMER_WIDTH-1:0]         timer_r;
  logic                           role_r;
  logic                           hv_r;

  localparam logic [TIMER_WIDTH-1:0] BLEED_LOAD = TIMER_WIDTH'(BLEED_CYCLES - 1);
  localparam logic [TIMER_WIDTH-1:0] GAP_LOAD   = TIMER_WIDTH'(SWAP_GAP_CYCLES - 1);

  wire timer_done = (timer_r == '0);
  wire role_change = attached && (want_source != role_r);
  wire leave_path = !attached || role_change;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      PORT_IDLE:
        if (attached)
          state_nxt = PORT_GAP;
      PORT_SINK, PORT_SOURCE:
        if (leave_path)
          state_nxt = PORT_BLEED;
      PORT_BLEED:
        if (timer_done)
          state_nxt = attached ? PORT_GAP : PORT_IDLE;
      PORT_GAP:
        if (!attached)
          state_nxt = PORT_IDLE;
        else if (timer_done)
          state_nxt = want_source ? PORT_SOURCE : PORT_SINK;
      default:
        state_nxt = PORT_IDLE;
    endcase
  end

  wire entering_timed = (state_nxt != state_r) &&
                        ((state_nxt == PORT_BLEED) || (state_nxt == PORT_GAP));

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_r        <= PORT_IDLE;
      timer_r        <= '0;
      role_r         <= 1'b0;
      hv_r           <= 1'b0;
      sink_path_en   <= 1'b0;
      source_path_en <= 1'b0;
      bus_bleed_ctrl <= 1'b0;
      event_pulse    <= 1'b0;
    end
    else if (clk_en)
    begin
      state_r <= state_nxt;
      timer_r <= entering_timed ? ((state_nxt == PORT_BLEED) ? BLEED_LOAD : GAP_LOAD)
               : (timer_done ? timer_r : timer_r - 1'b1);
      if (state_nxt == PORT_GAP)
        role_r <= want_source;
      hv_r <= attached && high_voltage;
      // The break-before-make gap keeps both paths low between roles.
      sink_path_en   <= (state_nxt == PORT_SINK);   // RULE7 RULE13
      source_path_en <= (state_nxt == PORT_SOURCE); // RULE8 RULE13
      // A bleed also runs when a high-voltage contract drops while attached.
      bus_bleed_ctrl <= (state_nxt == PORT_BLEED) ||
                        (hv_r && !high_voltage && attached); // RULE9 RULE10
      event_pulse    <= (state_r == PORT_IDLE && attached) ||
                        ((state_r == PORT_SINK || state_r == PORT_SOURCE) && leave_path); // RULE4
    end
  end

endmodule
`default_nettype wire

// ### rtl/typec_port_power_path_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module typec_port_power_path_ctrl
(
  // Clock, resets and enable
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  input  wire logic                 ext_reset_n,
  input  wire logic                 clk_en,
  // Per-port status from the line logic
  input  wire logic [power_path_pkg::NUM_PORTS-1:0] port_attached,
  input  wire logic [power_path_pkg::NUM_PORTS-1:0] port_want_source,
  input  wire logic [power_path_pkg::NUM_PORTS-1:0] port_high_voltage,
  // Requests decoded by the serial_comm_block from the embedded_host_ctrl
  input  wire logic                 irq_ack,
  input  wire logic                 lower_current_req,
  input  wire logic                 higher_vbus_allowed,
  // Power paths
  output logic [power_path_pkg::NUM_PORTS-1:0]      sink_path_en,
  output logic [power_path_pkg::NUM_PORTS-1:0]      source_path_en,
  output logic [power_path_pkg::NUM_PORTS-1:0]      bus_bleed_ctrl,
  // Terminations and negotiation
  output logic                      dead_batt_term_en,
  output logic                      active_term_en,
  output logic                      renegotiate_high_req,
  output logic                      renegotiate_low_req,
  // Event line to the embedded_host_ctrl
  output logic                      event_irq_n
);
  import power_path_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // The external reset is a pin, so it is synchronised before it is filtered.
  logic                      xr_meta_r;
  logic                      xr_sync_r;
  logic [RST_CNT_WIDTH-1:0]  xr_cnt_r;
  logic                      xr_hold_r;

  localparam logic [RST_CNT_WIDTH-1:0] XR_LIMIT = RST_CNT_WIDTH'(EXT_RESET_CYCLES);

  always_ff @(posedge sys_clk)
  begin
    xr_meta_r <= ext_reset_n;
    xr_sync_r <= xr_meta_r;
  end

  // Pulses shorter than the least hold time are ignored as glitches.
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n || xr_sync_r)
    begin
      xr_cnt_r  <= '0;
      xr_hold_r <= 1'b0;
    end
    else if (xr_cnt_r != XR_LIMIT)
      xr_cnt_r  <= xr_cnt_r + 1'b1;
    else
      xr_hold_r <= 1'b1; // RULE2
  end

  wire core_rst_n = reset_n && !xr_hold_r; // RULE1

  ////////////////////////////////////////////////////////////////////////////
  logic [NUM_PORTS-1:0] event_vec;

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++)
    begin : g_port
      port_path_fsm u_fsm (
        .sys_clk        (sys_clk),
        .rst_n          (core_rst_n),
        .clk_en         (clk_en),
        .attached       (port_attached[p]),
        .want_source    (port_want_source[p]),
        .high_voltage   (port_high_voltage[p]),
        .sink_path_en   (sink_path_en[p]),   // RULE6
        .source_path_en (source_path_en[p]), // RULE6
        .bus_bleed_ctrl (bus_bleed_ctrl[p]),
        .event_pulse    (event_vec[p])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // The pending flag is set by hardware and cleared by the host acknowledge;
  // a new event in the acknowledge cycle wins so it is never lost.
  wire any_event = |event_vec;
  logic powered_r;
  logic any_sink_r;

  always_ff @(posedge sys_clk)
  begin
    if (!core_rst_n)
    begin
      event_irq_n          <= 1'b1;
      dead_batt_term_en    <= 1'b1;
      active_term_en       <= 1'b0;
      powered_r            <= 1'b0;
      any_sink_r           <= 1'b0;
      renegotiate_high_req <= 1'b0;
      renegotiate_low_req  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (any_event)
        event_irq_n <= 1'b0; // RULE4
      else if (irq_ack)
        event_irq_n <= 1'b1; // RULE3
      powered_r         <= 1'b1;
      dead_batt_term_en <= 1'b0; // RULE11
      active_term_en    <= 1'b1; // RULE11
      // Sticky until reset, so the higher-voltage request goes out once per power-up.
      any_sink_r        <= any_sink_r || (|sink_path_en);
      // One request when the first sink contract after power-up starts.
      renegotiate_high_req <= powered_r && higher_vbus_allowed &&
                              (|sink_path_en) && !any_sink_r; // RULE12
      renegotiate_low_req  <= lower_current_req; // RULE5
    end
  end

endmodule
`default_nettype wire

// ### bench/power_path_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module power_path_asserts
(
  // Clock, resets and requests
  input wire logic                                sys_clk,
  input wire logic                                reset_n,
  input wire logic                                ext_reset_n,
  input wire logic                                clk_en,
  input wire logic [power_path_pkg::NUM_PORTS-1:0] port_attached,
  input wire logic [power_path_pkg::NUM_PORTS-1:0] port_want_source,
  input wire logic                                irq_ack,
  input wire logic                                lower_current_req,
  input wire logic                                higher_vbus_allowed,
  // Outputs watched
  input wire logic [power_path_pkg::NUM_PORTS-1:0] sink_path_en,
  input wire logic [power_path_pkg::NUM_PORTS-1:0] source_path_en,
  input wire logic [power_path_pkg::NUM_PORTS-1:0] bus_bleed_ctrl,
  input wire logic                                dead_batt_term_en,
  input wire logic                                active_term_en,
  input wire logic                                renegotiate_high_req,
  input wire logic                                renegotiate_low_req,
  input wire logic                                event_irq_n
);
  import power_path_pkg::*;
  logic [2:0] up_cnt_r;
  // The external reset reaches the core through a filter, so wait a few cycles after any release.
  always_ff @(posedge sys_clk)
    up_cnt_r <= (!reset_n || !ext_reset_n) ? 3'h0 : up_cnt_r + {2'h0, up_cnt_r != 3'h7};
  wire ready = (up_cnt_r == 3'h7) && clk_en;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_attach0;
    ready && $rose(port_attached[0]) && !port_want_source[0] && !bus_bleed_ctrl[0];
  endsequence
  sequence s_gap0;
    (!sink_path_en[0] && !source_path_en[0])[*8];
  endsequence
  a_path_after_gap: assert property (s_attach0 |-> s_gap0 ##[1:5] sink_path_en[0])
    else $error("sink path not enabled after gap");
  a_irq_on_attach: assert property (s_attach0 |-> ##[1:3] !event_irq_n)
    else $error("no event interrupt on attach");
  a_irq_holds: assert property (ready && !event_irq_n && !irq_ack |=> !event_irq_n)
    else $error("event interrupt dropped without ack");
  a_never_both: assert property (~|(sink_path_en & source_path_en))
    else $error("source and sink enabled together");
  a_swap_gap: assert property ($fell(sink_path_en[0]) |-> !source_path_en[0] [*8])
    else $error("source enabled right after sink");
  a_term_handoff: assert property (ready |-> !dead_batt_term_en && active_term_en)
    else $error("terminations not handed over");
  a_bleed_sink_off: assert property (ready && sink_path_en[0] && !port_attached[0]
    |=> bus_bleed_ctrl[0] && !sink_path_en[0])
    else $error("no bleed on sink detach");
  a_bleed_src_off: assert property (ready && source_path_en[1] && !port_attached[1]
    |=> bus_bleed_ctrl[1] && !source_path_en[1])
    else $error("no bleed on source detach");
  a_low_echo: assert property (ready |-> renegotiate_low_req == $past(lower_current_req))
    else $error("lower current request not echoed");
  a_high_pulse: assert property (ready && renegotiate_high_req
    |-> higher_vbus_allowed ##1 !renegotiate_high_req)
    else $error("higher voltage request malformed");
endmodule
bind typec_port_power_path_ctrl power_path_asserts i_chk (.sys_clk, .reset_n, .ext_reset_n,
  .clk_en, .port_attached, .port_want_source, .irq_ack, .lower_current_req,
  .higher_vbus_allowed, .sink_path_en, .source_path_en, .bus_bleed_ctrl, .dead_batt_term_en,
  .active_term_en, .renegotiate_high_req, .renegotiate_low_req, .event_irq_n);
`default_nettype wire

// ### bench/host_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_ctrl_model
(
  // Clock, event line and pacing
  input wire logic       sys_clk,
  input wire logic       event_irq_n,
  input wire logic [3:0] ack_delay,
  // Requests to the device
  output logic           irq_ack,
  output logic           lower_current_req
);
  // Bus master side: acknowledge each event after a chosen delay.
  initial
  begin
    irq_ack = 1'b0;
    lower_current_req = 1'b0;
    forever
    begin
      @(posedge sys_clk);
      #2;
      if (event_irq_n === 1'b0)
      begin
        repeat (ack_delay) @(posedge sys_clk);
        #2 irq_ack = 1'b1;
        @(posedge sys_clk);
        #2 irq_ack = 1'b0;
        repeat (2) @(posedge sys_clk);
      end
    end
  end
  task request_lower();
    @(posedge sys_clk);
    #2 lower_current_req = 1'b1;
    @(posedge sys_clk);
    #2 lower_current_req = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### bench/test_typec_port_power_path_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_typec_port_power_path_ctrl;
  import power_path_pkg::*;
  logic sys_clk = 0, reset_n = 0, ext_reset_n = 1, clk_en = 1, hv_ok = 1, b1_seen = 0;
  logic [1:0] att = 0, want_src = 0, hv = 0;
  logic [3:0] ack_dly = 4'h8;
  wire logic [1:0] snk, src, bleed;
  wire logic irq_ack, low_req, dbt, act, hi_req, lo_req, irq_n;
  int num_errors = 0, compares = 0, cyc = 0, hi_cnt = 0, k;
  always #12.5 sys_clk = ~sys_clk;
  typec_port_power_path_ctrl i_dut (.sys_clk, .reset_n, .ext_reset_n, .clk_en,
    .port_attached(att), .port_want_source(want_src), .port_high_voltage(hv), .irq_ack,
    .lower_current_req(low_req), .higher_vbus_allowed(hv_ok), .sink_path_en(snk),
    .source_path_en(src), .bus_bleed_ctrl(bleed), .dead_batt_term_en(dbt),
    .active_term_en(act), .renegotiate_high_req(hi_req), .renegotiate_low_req(lo_req),
    .event_irq_n(irq_n));
  host_ctrl_model i_host (.sys_clk, .event_irq_n(irq_n), .ack_delay(ack_dly), .irq_ack,
    .lower_current_req(low_req));
  ////////////////////////////////////////////////////////////////////////////////
  task check(input logic [3:0] seen, input logic [3:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  task report_and_stop();
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Cut a hang short well past the longest expected run of about 555 cycles.
  // Pulses are counted at the falling edge, where the outputs have settled.
  always @(negedge sys_clk)
  begin
    cyc++;
    if (hi_req === 1'b1) hi_cnt++;
    if (bleed[1] === 1'b1) b1_seen = 1'b1;
    if (cyc == 4000)
    begin
      num_errors++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    step(8);
    reset_n = 1;
    step(8);
    check({dbt, act, snk}, 4'h4);
    check({2'h0, src}, 4'h0);
    $display("reset test done");
    att[0] = 1;
    step(3);
    check({3'h0, irq_n}, 4'h0);
    for (k = 0; k < 20 && snk[0] !== 1'b1; k++) step(1);
    check({src, snk}, 4'h1);
    i_host.request_lower();
    check({3'h0, lo_req}, 4'h1);
    check(4'(hi_cnt), 4'h1);
    $display("sink test done");
    step(1);
    // A frozen block must keep the sink path through a role request.
    clk_en = 0;
    want_src[0] = 1;
    step(3);
    check({1'h0, bleed[0], snk[0], src[0]}, 4'h2);
    clk_en = 1;
    step(2);
    check({1'h0, bleed[0], snk[0], src[0]}, 4'h4);
    for (k = 0; k < 500 && src[0] !== 1'b1; k++) step(1);
    check({1'h0, bleed[0], snk[0], src[0]}, 4'h1);
    $display("swap test done");
    ack_dly = 4'h0;
    att[1] = 1;
    want_src[1] = 1;
    for (k = 0; k < 20 && src[1] !== 1'b1; k++) step(1);
    hv[1] = 1;
    step(3);
    hv[1] = 0;
    step(3);
    check({3'h0, b1_seen}, 4'h1);
    att[1] = 0;
    step(2);
    check({2'h0, bleed[1], src[1]}, 4'h2);
    $display("bleed test done");
    // A pulse shorter than the least hold time must not reset the block.
    ext_reset_n = 0;
    step(20);
    ext_reset_n = 1;
    step(5);
    check({2'h0, src[0], act}, 4'h3);
    ext_reset_n = 0;
    step(50);
    check({src, dbt, irq_n}, 4'h3);
    want_src[0] = 0;
    hv_ok = 0;
    ext_reset_n = 1;
    step(10);
    check({3'h0, act}, 4'h1);
    $display("external reset test done");
    for (k = 0; k < 20 && snk[0] !== 1'b1; k++) step(1);
    check({src, snk}, 4'h1);
    check(4'(hi_cnt), 4'h1);
    att[0] = 0;
    step(2);
    check({2'h0, bleed[0], snk[0]}, 4'h2);
    $display("detach test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
